// *** rtl/pic_pkg.sv ***
// Summary of operation
// - Each exception source is tied to a fixed stage: I, R, A or D.
// - A detected exception cancels its instruction and every younger one.
// - Cancelled instructions raise no stalls and no further exceptions.
// - At W the flag updates coprocessor state, redirects fetch, clears earlier flags.
// - Older instructions complete; younger never complete after an exception.
// - An older exception detected later kills a younger flagged instruction.
// - Conditions after R stop the whole pipeline until resolved.
// - Data cache miss found in D; a dirty victim moves out the cycle after the buffer is empty.
// - Data refill restarts the pipeline on the first doubleword.
// - Victim data goes to memory only after the whole new line returns.
// - Issue only with operands and resources ready; otherwise slip and retry.
// - During a slip D and W advance and bubbles fill the gap.
// - Instructions killed by branch-likely, return or exception slip only while an instruction line fill is in progress.
// - Instruction cache miss found in R slips the pipeline; no write-back.
// - Instruction cache miss loads the whole line before restart.
// - All external writes go through the write buffer.
// - The write buffer holds at most four address and data pairs.
// - A victim write-back takes the whole buffer while the core continues.
// - A store meeting a full write buffer stalls until room appears.
// - Exception and interlock conditions are checked every cycle for every stage before W.
// - Stalls halt every pipeline stage; slips advance the back end, hold the front.
package pic_pkg;
   // ********************************************************
   // Stage indices, sizes and source bit positions
   // ********************************************************
   localparam int ST_R = 0;
   localparam int ST_A = 1;
   localparam int ST_D = 2;
   localparam int ST_W = 3;
   localparam int WB_DEPTH = 4;
   localparam int WB_AW = 64;
   localparam int WB_DW = 64;
   localparam int R_EXC_W = 2;
   localparam int A_EXC_W = 7;
   localparam int D_EXC_W = 6;
   localparam int SLIP_W = 3;
   // R: bus error 0, parity 1. A: reserved 0, cop unusable 1, break 2,
   // syscall 3, data translation 4, page modified 5, interrupt 6.
   // D: bus error 0, nmi 1, reset 2, parity 3, overflow 4, trap 5.
   localparam logic [3:0] CODE_I = 4'h0;
   localparam logic [3:0] CODE_R = 4'h1;
   localparam logic [3:0] CODE_A = 4'h3;
   localparam logic [3:0] CODE_D = 4'hA;
   typedef enum logic [1:0] {DC_IDLE, DC_VICT, DC_FILL, DC_REST} pic_dc_e;
endpackage

// *** rtl/pic_ctrl.sv ***
`timescale 1ns/1ns
module pic_ctrl #(
   parameter int DEPTH = pic_pkg::WB_DEPTH,
   parameter int AW = pic_pkg::WB_AW,
   parameter int DW = pic_pkg::WB_DW
) (
   input wire logic I_CLOCK, // Processor clock.
   input wire logic I_RST, // Asynchronous reset, high.
   input wire logic I_FETCH_VALID, // Fetched instruction enters R.
   input wire logic I_I_EXC, // Instruction translation exception.
   input wire logic [pic_pkg::R_EXC_W-1:0] I_R_EXC, // R stage sources.
   input wire logic [pic_pkg::A_EXC_W-1:0] I_A_EXC, // A stage sources.
   input wire logic [pic_pkg::D_EXC_W-1:0] I_D_EXC, // D stage sources.
   input wire logic I_BR_KILL_R, // R instruction killed by branch or return.
   input wire logic [pic_pkg::SLIP_W-1:0] I_SLIP_REQ, // Load, muldiv, fp busy.
   input wire logic I_ICACHE_MISS, // Instruction cache miss in R.
   input wire logic I_ILINE_DONE, // Whole instruction line loaded.
   input wire logic I_DCACHE_MISS, // Data cache miss in D.
   input wire logic I_VICTIM_DIRTY, // Victim line is dirty.
   input wire logic I_DREFILL_FIRST, // First refill doubleword written.
   input wire logic I_DREFILL_LAST, // Last refill doubleword written.
   input wire logic I_STORE_D, // D holds an uncached or write-through store.
   input wire logic [AW-1:0] I_STORE_ADDR, // Store address.
   input wire logic [DW-1:0] I_STORE_DATA, // Store data.
   input wire logic I_VICT_VALID, // Victim doubleword offered.
   input wire logic [AW-1:0] I_VICT_ADDR, // Victim address.
   input wire logic [DW-1:0] I_VICT_DATA, // Victim data.
   input wire logic I_MEM_WREADY, // Memory takes a write.
   output logic [3:0] O_STAGE_VALID, // Valid bits of R, A, D, W.
   output logic O_ADV_I, // Fetch stage advances.
   output logic O_STALL, // Whole pipeline frozen.
   output logic O_SLIP, // Front end held, back end advancing.
   output logic O_EXC_TAKE, // Commit exception, redirect to vector.
   output logic [3:0] O_EXC_CODE, // Code of the exception in W.
   output logic O_W_COMPLETE, // W instruction completes.
   output logic O_IFILL_REQ, // Instruction line fill in progress.
   output logic O_DFILL_REQ, // Data refill awaited.
   output logic O_VICTIM_MOVE, // Move dirty victim into buffer.
   output logic O_STORE_ACCEPT, // Store written into buffer.
   output logic O_MEM_WVALID, // Buffer offers a write.
   output logic [AW-1:0] O_MEM_WADDR, // Write address.
   output logic [DW-1:0] O_MEM_WDATA, // Write data.
   output logic [$clog2(DEPTH+1)-1:0] O_WB_COUNT // Buffer fill level.
);
   localparam int CW = $clog2(DEPTH + 1);
   localparam int PW = $clog2(DEPTH);

   // ********************************************************
   // Exception bookkeeping
   // ********************************************************
   // Lowest set source wins; its code is base plus position.
   function automatic logic [3:0] enc(input logic [6:0] src, input logic [3:0] base);
      logic [2:0] idx;
      idx = 3'h0;
      for (int i = 6; i >= 0; i--) begin
         if (src[i]) begin
            idx = 3'(i);
         end
      end
      return base + {1'b0, idx};
   endfunction

   logic [3:0] v_ff, x_ff, nxt_v, nxt_x;
   logic [3:0][3:0] c_ff, nxt_c;
   logic ic_busy_ff, vic_ff;
   pic_pkg::pic_dc_e dc_st_ff, nxt_dc;
   logic [AW-1:0] wa_mem [DEPTH];
   logic [DW-1:0] wd_mem [DEPTH];
   logic [PW-1:0] wp_ff, rp_ff;
   logic [CW-1:0] cnt_ff;

   // Detection only for instructions not already flagged; only R also skips branch-killed ones.
   wire [3:0] det;
   wire [3:0] exc_any;
   wire [3:0] kill;
   wire [3:0] live;
   wire kill_f;
   wire [3:0] enc_r = enc({5'h00, I_R_EXC}, pic_pkg::CODE_R);
   wire [3:0] enc_a = enc(I_A_EXC, pic_pkg::CODE_A);
   wire [3:0] enc_d = enc({1'b0, I_D_EXC}, pic_pkg::CODE_D);
   assign det[0] = v_ff[0] & ~x_ff[0] & ~I_BR_KILL_R & (|I_R_EXC);
   assign det[1] = v_ff[1] & ~x_ff[1] & (|I_A_EXC);
   assign det[2] = v_ff[2] & ~x_ff[2] & (|I_D_EXC);
   assign det[3] = 1'b0;
   assign exc_any = (v_ff & x_ff) | det;
   // Anything younger than a flagged instruction is cancelled.
   assign kill[3] = 1'b0;
   assign kill[2] = exc_any[3];
   assign kill[1] = |exc_any[3:2];
   assign kill[0] = (|exc_any[3:1]) | I_BR_KILL_R;
   assign kill_f = |exc_any;
   assign live = v_ff & ~x_ff & ~det & ~kill;

   // ********************************************************
   // Interlock decisions
   // ********************************************************
   // Full compares against the depth parameter and empty against zero, so a deeper power-of-two buffer works as is.
   wire wb_full = cnt_ff == CW'(DEPTH);
   wire wb_empty = cnt_ff == '0;
   wire dm_new = live[pic_pkg::ST_D] & I_DCACHE_MISS;
   wire dc_hold = (dc_st_ff == pic_pkg::DC_VICT) | (dc_st_ff == pic_pkg::DC_FILL);
   // A victim owns the whole buffer, so stores wait while it is held.
   wire st_full = live[pic_pkg::ST_D] & I_STORE_D & (wb_full | vic_ff);
   wire stall = dm_new | dc_hold | st_full;
   wire ic_new = live[pic_pkg::ST_R] & I_ICACHE_MISS;
   wire slip_req = live[pic_pkg::ST_R] & (|I_SLIP_REQ);
   wire slip = ~stall & (ic_busy_ff | ic_new | slip_req);
   wire take = v_ff[pic_pkg::ST_W] & x_ff[pic_pkg::ST_W] & ~stall;
   wire dc_go = (dc_st_ff == pic_pkg::DC_IDLE) & dm_new & (~I_VICTIM_DIRTY | wb_empty);

   assign O_STALL = stall;
   assign O_SLIP = slip;
   assign O_ADV_I = ~stall & ~slip & ~take;
   assign O_EXC_TAKE = take;
   assign O_EXC_CODE = c_ff[pic_pkg::ST_W];
   assign O_W_COMPLETE = v_ff[pic_pkg::ST_W] & ~x_ff[pic_pkg::ST_W] & ~stall;
   assign O_STAGE_VALID = v_ff;
   assign O_IFILL_REQ = ic_busy_ff;
   assign O_DFILL_REQ = dc_st_ff == pic_pkg::DC_FILL;
   assign O_VICTIM_MOVE = dc_st_ff == pic_pkg::DC_VICT;

   // ********************************************************
   // Stage advance
   // ********************************************************
   // Flags and codes travel with instructions; a commit flushes all.
   always_comb begin
      nxt_v = v_ff;
      nxt_x = x_ff;
      nxt_c = c_ff;
      if (take) begin
         nxt_v = '0;
         nxt_x = '0;
      end else if (!stall) begin
         nxt_v[3] = v_ff[2] & ~kill[2];
         nxt_x[3] = x_ff[2] | det[2];
         nxt_c[3] = x_ff[2] ? c_ff[2] : enc_d;
         nxt_v[2] = v_ff[1] & ~kill[1];
         nxt_x[2] = x_ff[1] | det[1];
         nxt_c[2] = x_ff[1] ? c_ff[1] : enc_a;
         if (slip) begin
            nxt_v[1] = 1'b0;
            nxt_x[1] = 1'b0;
            nxt_v[0] = v_ff[0] & ~kill[0];
            nxt_x[0] = x_ff[0] | det[0];
            nxt_c[0] = x_ff[0] ? c_ff[0] : enc_r;
         end else begin
            nxt_v[1] = v_ff[0] & ~kill[0];
            nxt_x[1] = x_ff[0] | det[0];
            nxt_c[1] = x_ff[0] ? c_ff[0] : enc_r;
            nxt_v[0] = I_FETCH_VALID & ~kill_f;
            nxt_x[0] = I_I_EXC;
            nxt_c[0] = pic_pkg::CODE_I;
         end
      end
   end

   // All stage bits share one bank, so a flag never drifts away from its instruction.
   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         v_ff <= '0;
         x_ff <= '0;
         c_ff <= '0;
      end else begin
         v_ff <= nxt_v;
         x_ff <= nxt_x;
         c_ff <= nxt_c;
      end
   end

   // ********************************************************
   // Cache miss sequencing
   // ********************************************************
   // No early restart for instruction misses: wait for the whole line.
   // Completion beats a miss seen in the same cycle, as that miss is the line just loaded.
   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         ic_busy_ff <= 1'b0;
      end else if (I_ILINE_DONE) begin
         ic_busy_ff <= 1'b0;
      end else if (ic_new & ~stall) begin
         ic_busy_ff <= 1'b1;
      end
   end

   // Dirty victim waits for an empty buffer, since it needs all entries.
   always_comb begin
      nxt_dc = dc_st_ff;
      case (dc_st_ff)
         pic_pkg::DC_IDLE: begin
            if (dc_go) begin
               nxt_dc = I_VICTIM_DIRTY ? pic_pkg::DC_VICT : pic_pkg::DC_FILL;
            end
         end
         pic_pkg::DC_VICT: begin
            nxt_dc = pic_pkg::DC_FILL;
         end
         pic_pkg::DC_FILL: begin
            if (I_DREFILL_FIRST) begin
               nxt_dc = pic_pkg::DC_REST;
            end
         end
         pic_pkg::DC_REST: begin
            if (I_DREFILL_LAST) begin
               nxt_dc = pic_pkg::DC_IDLE;
            end
         end
         default: begin
            nxt_dc = pic_pkg::DC_IDLE;
         end
      endcase
   end

   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         dc_st_ff <= pic_pkg::DC_IDLE;
         vic_ff <= 1'b0;
      end else begin
         dc_st_ff <= nxt_dc;
         vic_ff <= (dc_go & I_VICTIM_DIRTY) | (vic_ff & (nxt_dc != pic_pkg::DC_IDLE));
      end
   end

   // ********************************************************
   // Write buffer
   // ********************************************************
   // Stores and victim words are never offered in the same cycle.
   wire push_st = live[pic_pkg::ST_D] & I_STORE_D & ~stall;
   wire push_v = I_VICT_VALID & vic_ff & ~wb_full;
   wire push = push_st | push_v;
   wire pop = O_MEM_WVALID & I_MEM_WREADY;
   wire [AW-1:0] push_a = push_v ? I_VICT_ADDR : I_STORE_ADDR;
   wire [DW-1:0] push_d = push_v ? I_VICT_DATA : I_STORE_DATA;

   assign O_STORE_ACCEPT = push_st;
   assign O_MEM_WVALID = ~wb_empty & ~vic_ff;
   assign O_MEM_WADDR = wa_mem[rp_ff];
   assign O_MEM_WDATA = wd_mem[rp_ff];
   assign O_WB_COUNT = cnt_ff;

   // The array has no reset; the count alone says which words are meaningful.
   always_ff @(posedge I_CLOCK) begin
      if (push) begin
         wa_mem[wp_ff] <= push_a;
         wd_mem[wp_ff] <= push_d;
      end
   end

   // Pointers wrap over a power-of-two depth.
   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         wp_ff <= '0;
         rp_ff <= '0;
         cnt_ff <= '0;
      end else begin
         wp_ff <= wp_ff + PW'(push);
         rp_ff <= rp_ff + PW'(pop);
         cnt_ff <= cnt_ff + CW'(push) - CW'(pop);
      end
   end

   // ********************************************************
   // Assertions
   // ********************************************************
   default clocking @(posedge I_CLOCK); endclocking
   default disable iff (I_RST);

   commit_flush_a: assert property (O_EXC_TAKE |=> O_STAGE_VALID == 4'h0)
      else $error("pipeline not flushed after exception commit");
   stall_freeze_a: assert property (O_STALL |=> $stable(O_STAGE_VALID))
      else $error("stage valid bits moved during stall");
   slip_bubble_a: assert property (O_SLIP |=> !O_STAGE_VALID[1])
      else $error("no bubble inserted into A on slip");
   victim_move_a: assert property (dc_go && I_VICTIM_DIRTY |=>
      O_VICTIM_MOVE ##1 O_DFILL_REQ)
      else $error("dirty victim not moved the next cycle");
   drain_hold_a: assert property (vic_ff |-> !O_MEM_WVALID)
      else $error("victim drained before refill end");
   wb_depth_a: assert property (O_WB_COUNT <= CW'(DEPTH))
      else $error("write buffer over depth");
   full_stall_a: assert property (st_full |-> O_STALL && !O_STORE_ACCEPT)
      else $error("store accepted into full buffer");
   ifill_hold_a: assert property (O_IFILL_REQ |-> !O_ADV_I)
      else $error("fetch advanced during line fill");
   killed_slip_a: assert property (I_BR_KILL_R && !O_IFILL_REQ |-> !O_SLIP)
      else $error("killed instruction caused slip");
   refill_go_a: assert property (O_DFILL_REQ && I_DREFILL_FIRST |=> !O_DFILL_REQ)
      else $error("no restart after first doubleword");
   // A detected exception drops the instruction behind it at once.
   young_kill_a: assert property (det[1] && !O_STALL |=> !O_STAGE_VALID[1])
      else $error("younger instruction survived an exception");
   // A cancelled instruction must never hold the pipe for its own miss or store.
   dead_stall_a: assert property ((|exc_any[3:2]) && !dc_hold |-> !O_STALL)
      else $error("stall raised for a cancelled instruction");

   // ********************************************************
   // Cover points
   // ********************************************************
   take_cov: cover property (O_EXC_TAKE);
   slip_cov: cover property (O_SLIP ##1 O_SLIP);
   victim_cov: cover property (O_VICTIM_MOVE ##[1:20] I_DREFILL_LAST);
   full_cov: cover property (st_full);
   store_cov: cover property (O_STORE_ACCEPT ##1 O_MEM_WVALID);
endmodule

// *** verif/pic_far_model.sv ***
`timescale 1ns/1ns
module pic_far_model (
   input wire logic i_clock, // Clock.
   input wire logic i_rst, // Reset, high.
   input wire logic i_want_dmiss, // Data miss wanted.
   input wire logic i_want_imiss, // Instr miss wanted.
   input wire logic i_dirty, // Victim is dirty.
   input wire logic i_mem_hold, // Memory refuses writes.
   input wire logic i_dfill_req, // Data fill awaited.
   input wire logic i_ifill_req, // Instr fill busy.
   input wire logic i_mem_wvalid, // Write offered.
   output logic o_dmiss, // Data miss.
   output logic o_imiss, // Instr miss.
   output logic o_iline_done, // Instr line loaded.
   output logic o_first, // First refill word.
   output logic o_last, // Last refill word.
   output logic o_vict_valid, // Victim word valid.
   output logic [63:0] o_vict_addr, // Victim address.
   output logic [63:0] o_vict_data, // Victim data.
   output logic o_mem_wready // Write taken.
);
   logic [3:0] dcnt_ff;
   logic [2:0] icnt_ff;
   logic [2:0] vcnt_ff;
   logic dserv_ff;
   logic iserv_ff;
   logic slow_ff;
   // A served miss reads as a hit, as the refilled line now sits in the cache.
   assign o_dmiss = i_want_dmiss & ~dserv_ff;
   assign o_imiss = i_want_imiss & ~iserv_ff;
   assign o_first = dcnt_ff == 4'h4;
   assign o_last = dcnt_ff == 4'h7;
   assign o_iline_done = icnt_ff == 3'h5;
   assign o_vict_valid = i_dfill_req & i_dirty & (vcnt_ff < 3'h4);
   // Idle lines show the inverse, so a stale word never passes for a fresh one.
   assign o_vict_addr = o_vict_valid ? {61'h0, vcnt_ff} : ~{61'h0, vcnt_ff};
   assign o_vict_data = o_vict_valid ? {61'hA5, vcnt_ff} : ~{61'hA5, vcnt_ff};
   // Memory is slow: it takes a write only every other cycle.
   assign o_mem_wready = i_mem_wvalid & ~i_mem_hold & slow_ff;
   // Refill and line-load timing counters.
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         dcnt_ff <= 4'h0;
         icnt_ff <= 3'h0;
         vcnt_ff <= 3'h0;
         dserv_ff <= 1'b0;
         iserv_ff <= 1'b0;
         slow_ff <= 1'b0;
      end else begin
         dcnt_ff <= (dcnt_ff != 4'h7 && (i_dfill_req || dcnt_ff != 4'h0)) ? dcnt_ff + 4'h1 : 4'h0;
         icnt_ff <= (i_ifill_req && icnt_ff != 3'h5) ? icnt_ff + 3'h1 : 3'h0;
         vcnt_ff <= i_dfill_req ? vcnt_ff + {2'h0, o_vict_valid} : 3'h0;
         dserv_ff <= i_want_dmiss & (dserv_ff | o_first);
         iserv_ff <= i_want_imiss & (iserv_ff | o_iline_done);
         slow_ff <= ~slow_ff;
      end
   end
endmodule

// *** verif/pipeline_interlock_exception_ctrl_tb_top.sv ***
`timescale 1ns/1ns
module pipeline_interlock_exception_ctrl_tb_top;
   typedef struct {int stg; int bi; logic [3:0] code;} pic_row_s;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic fetch = 1'b0;
   logic i_exc = 1'b0;
   logic [1:0] r_exc = '0;
   logic [6:0] a_exc = '0;
   logic [5:0] d_exc = '0;
   logic kill = 1'b0;
   logic [2:0] slip = '0;
   logic dirty = 1'b0;
   logic st = 1'b0;
   logic [63:0] st_addr = '0;
   logic want_d = 1'b0;
   logic want_i = 1'b0;
   logic hold = 1'b0;
   logic dmiss, imiss, idone, first, last, vval, wready, adv, stall, slp, take;
   logic ifill, dfill, vmove, acc, wval, seen_last, restart, wcomp;
   logic [63:0] vaddr, vdata, waddr, wdata;
   logic [3:0] valid, code;
   logic [2:0] cnt;
   int err_total = 0;
   int n_checks = 0;
   int cyc = 0;
   int peak;
   pic_row_s rows[16];
   pic_ctrl u_dut (.I_CLOCK(clk), .I_RST(rst), .I_FETCH_VALID(fetch), .I_I_EXC(i_exc),
      .I_R_EXC(r_exc), .I_A_EXC(a_exc), .I_D_EXC(d_exc), .I_BR_KILL_R(kill), .I_SLIP_REQ(slip),
      .I_ICACHE_MISS(imiss), .I_ILINE_DONE(idone), .I_DCACHE_MISS(dmiss), .I_VICTIM_DIRTY(dirty),
      .I_DREFILL_FIRST(first), .I_DREFILL_LAST(last), .I_STORE_D(st), .I_STORE_ADDR(st_addr),
      .I_STORE_DATA(~st_addr), .I_VICT_VALID(vval), .I_VICT_ADDR(vaddr), .I_VICT_DATA(vdata),
      .I_MEM_WREADY(wready), .O_STAGE_VALID(valid), .O_ADV_I(adv), .O_STALL(stall), .O_SLIP(slp),
      .O_EXC_TAKE(take), .O_EXC_CODE(code), .O_W_COMPLETE(wcomp), .O_IFILL_REQ(ifill),
      .O_DFILL_REQ(dfill), .O_VICTIM_MOVE(vmove), .O_STORE_ACCEPT(acc), .O_MEM_WVALID(wval),
      .O_MEM_WADDR(waddr), .O_MEM_WDATA(wdata), .O_WB_COUNT(cnt));
   pic_far_model u_far (.i_clock(clk), .i_rst(rst), .i_want_dmiss(want_d), .i_want_imiss(want_i),
      .i_dirty(dirty), .i_mem_hold(hold), .i_dfill_req(dfill), .i_ifill_req(ifill),
      .i_mem_wvalid(wval), .o_dmiss(dmiss), .o_imiss(imiss), .o_iline_done(idone),
      .o_first(first), .o_last(last), .o_vict_valid(vval), .o_vict_addr(vaddr),
      .o_vict_data(vdata), .o_mem_wready(wready));
   // Free-running clock; a hang is cut short well past the expected run length.
   always #10 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 4000) begin
         err_total++;
         wrap_up();
      end
   end
   // Comparison with report on mismatch.
   task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %s expected %0h seen %0h", nm, exp, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Raises or drops one exception source of the given stage.
   task automatic inject(input int s, input int b, input logic v);
      case (s)
         0: i_exc = v;
         1: r_exc[b] = v;
         2: a_exc[b] = v;
         default: d_exc[b] = v;
      endcase
   endtask
   // Waits for the commit, checks its code, then that the pipe is flushed.
   task automatic take_code(input logic [3:0] exp);
      for (int k = 0; k < 10 && take !== 1'b1; k++) tick(1);
      chk("exc_take", 1, take);
      chk("exc_complete", 0, wcomp);
      chk("exc_code", exp, code);
      tick(1);
      chk("valid_flush", 4'h0, valid);
   endtask
   task automatic wrap_up();
      if (err_total == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Main sequence: table of exception sources first, awkward cases after.
   initial begin
      for (int k = 0; k < 16; k++) begin
         rows[k].stg = (k == 0) ? 0 : (k < 3) ? 1 : (k < 10) ? 2 : 3;
         rows[k].bi = (k == 0) ? 0 : (k < 3) ? k - 1 : (k < 10) ? k - 3 : k - 10;
         rows[k].code = (k == 0) ? pic_pkg::CODE_I : (k < 3) ? pic_pkg::CODE_R + 4'(k - 1) :
            (k < 10) ? pic_pkg::CODE_A + 4'(k - 3) : pic_pkg::CODE_D + 4'(k - 10);
      end
      tick(8);
      chk("rst_valid", 4'h0, valid);
      chk("rst_adv", 1, adv);
      chk("rst_count", 0, cnt);
      rst = 1'b0;
      fetch = 1'b1;
      foreach (rows[k]) begin
         tick(4);
         inject(rows[k].stg, rows[k].bi, 1'b1);
         tick(1);
         inject(rows[k].stg, rows[k].bi, 1'b0);
         take_code(rows[k].code);
      end
      tick(4);
      a_exc[0] = 1'b1;
      tick(1);
      a_exc = '0;
      chk("kill_young", 2'h0, valid[1:0]);
      want_d = 1'b1;
      #1 chk("dead_stall", 0, stall);
      chk("older_done", 1, wcomp);
      want_d = 1'b0;
      take_code(pic_pkg::CODE_A);
      tick(4);
      a_exc[0] = 1'b1;
      d_exc[4] = 1'b1;
      tick(1);
      a_exc = '0;
      d_exc = '0;
      take_code(pic_pkg::CODE_D + 4'h4);
      tick(4);
      r_exc[0] = 1'b1;
      tick(1);
      r_exc = '0;
      d_exc[1] = 1'b1;
      tick(1);
      d_exc = '0;
      take_code(pic_pkg::CODE_D + 4'h1);
      for (int b = 0; b < 3; b++) begin
         tick(4);
         slip[b] = 1'b1;
         #1 chk("slip", 1, slp);
         chk("slip_adv", 0, adv);
         tick(1);
         chk("bubble", 0, valid[1]);
         chk("back_end", 2'h3, valid[3:2]);
         slip = '0;
      end
      tick(4);
      kill = 1'b1;
      slip[0] = 1'b1;
      #1 chk("killed_slip", 0, slp);
      tick(1);
      kill = 1'b0;
      slip = '0;
      tick(4);
      want_i = 1'b1;
      #1 chk("imiss_slip", 1, slp);
      tick(1);
      for (int k = 0; k < 20 && ifill === 1'b1; k++) begin
         chk("fill_slip", 1, slp);
         tick(1);
      end
      want_i = 1'b0;
      chk("ifill_end", 0, ifill);
      chk("no_ibuf", 0, cnt);
      tick(4);
      dirty = 1'b1;
      want_d = 1'b1;
      #1 chk("dmiss_stall", 1, stall);
      tick(1);
      chk("victim_move", 1, vmove);
      seen_last = 1'b0;
      restart = 1'b0;
      peak = 0;
      for (int k = 0; k < 40; k++) begin
         tick(1);
         if (stall === 1'b0 && !restart) begin
            restart = 1'b1;
            chk("early_restart", 0, seen_last);
         end
         if (wval === 1'b1 && !seen_last) chk("victim_held", 0, wval);
         if (last === 1'b1) seen_last = 1'b1;
         if (int'(cnt) > peak) peak = int'(cnt);
      end
      want_d = 1'b0;
      dirty = 1'b0;
      chk("restarted", 1, restart);
      chk("victim_fill", 4, peak);
      chk("victim_drain", 0, cnt);
      hold = 1'b1;
      st = 1'b1;
      for (int k = 0; k < 5; k++) begin
         st_addr = 64'h100 + 64'(k);
         #1 chk("store_take", k < 4, acc);
         tick(1);
      end
      chk("full_stall", 1, stall);
      chk("full_count", 4, cnt);
      chk("head_addr", 64'h100, waddr);
      chk("head_data", ~64'h100, wdata);
      hold = 1'b0;
      for (int k = 0; k < 10 && acc !== 1'b1; k++) tick(1);
      chk("store_late", 1, acc);
      tick(1);
      st = 1'b0;
      tick(20);
      chk("store_drain", 0, cnt);
      wrap_up();
   end
endmodule
